/* swc_consts.svh */
// named offsets, field positions, reset values and timing counts of the sleep/wake block
`ifndef SWC_CONSTS_SVH
`define SWC_CONSTS_SVH

// apb byte addresses
`define SWC_ADDR_W            8
`define SWC_OFF_STATUS        8'h00
`define SWC_OFF_OPTION        8'h04
`define SWC_OFF_STATE         8'h08
`define SWC_OFF_IRQ_STAT      8'h0c
`define SWC_OFF_IRQ_MASK      8'h10

// status register fields
`define SWC_ST_PIN_WAKE       7
`define SWC_ST_TIMEOUT_N      4
`define SWC_ST_POWERDOWN_N    3

// option register fields and reset value
`define SWC_OPT_PIN_WAKE_EN_N 7
`define SWC_OPT_CLEAR_MODE    1
`define SWC_OPT_WATCHDOG_EN   0
`define SWC_OPT_W             8
`define SWC_OPT_RESET         8'h82

// state register fields
`define SWC_STATE_SLEEP       0
`define SWC_STATE_SNAP_LO     1
`define SWC_STATE_SNAP_HI     3
`define SWC_STATE_LIVE_LO     4
`define SWC_STATE_LIVE_HI     6

// interrupt status / mask fields
`define SWC_IRQ_W             3
`define SWC_IRQ_SLEEP         0
`define SWC_IRQ_WAKE          1
`define SWC_IRQ_WATCHDOG      2

// port pads and watched pins
`define SWC_PAD_W             5
`define SWC_PIN_W             3

// watchdog timing
`define SWC_CLK_PERIOD_NS     10
`define SWC_WATCHDOG_TIME_NS  40960
`define SWC_WATCHDOG_W        12
`define SWC_WATCHDOG_LIMIT    (`SWC_WATCHDOG_TIME_NS / `SWC_CLK_PERIOD_NS - 1)

`endif

/* swc_pkg.sv */
// types shared by the sleep/wake control block
package swc_pkg;
	`include "swc_consts.svh"

	typedef enum logic {
		ST_RUN,
		ST_SLEEP
	} swc_state_t;

	// drive state of the port pads
	typedef struct packed {
		logic [`SWC_PAD_W-1:0] level;
		logic [`SWC_PAD_W-1:0] drive;
	} swc_pad_t;

	// reset-cause flags as software sees them
	typedef struct packed {
		logic pin_wake_flag;
		logic timeout_flag_n;
		logic powerdown_flag_n;
	} swc_flags_t;

	// watched pins: shared pin, pin 1, pin 0
	typedef struct packed {
		logic pin3;
		logic pin1;
		logic pin0;
	} swc_wpins_t;
endpackage

/* swc_watchdog.sv */
// watchdog counter with clear and one-cycle expiry pulse
`timescale 1ns/1ns
module swc_watchdog
	import swc_pkg::*;
(
	input  wire logic                       pclk,    // block clock
	input  wire logic                       presetn, // async reset, low
	input  wire logic                       run_en,  // count while high
	input  wire logic                       clear,   // restart from zero
	output logic      [`SWC_WATCHDOG_W-1:0] count,   // watchdog_counter value
	output logic                            expire   // one-cycle time-out
);
	logic [`SWC_WATCHDOG_W-1:0] count_reg;
	logic [`SWC_WATCHDOG_W-1:0] count_next;
	logic                       at_limit;

	// limit reached only while counting
	assign at_limit = run_en && (count_reg == `SWC_WATCHDOG_W'(`SWC_WATCHDOG_LIMIT));

	// clear wins over counting; expiry wraps to zero
	assign count_next = (clear || at_limit || !run_en) ? '0 :
		count_reg + `SWC_WATCHDOG_W'(1);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			count_reg <= '0;
		end else begin
			count_reg <= count_next;
		end
	end

	assign count  = count_reg;
	// expiry ignores clear: the wake and sleep paths feed clear back from it
	assign expire = at_limit;
endmodule

/* swc_sleep_wakeup_control.sv */
// sleep entry, wake-up sources, reset-cause flags and apb registers
//
// Our own choices: the APB interface to the registers and the placing of the registers.
`timescale 1ns/1ns
module swc_sleep_wakeup_control
	import swc_pkg::*;
(
	input  wire logic                    pclk,                     // block clock
	input  wire logic                    presetn,                  // power-up reset, low
	input  wire logic                    psel,                     // apb select
	input  wire logic                    penable,                  // apb access phase
	input  wire logic                    pwrite,                   // apb direction
	input  wire logic [`SWC_ADDR_W-1:0]  paddr,                    // apb byte address
	input  wire logic [31:0]             pwdata,                   // apb write data
	output logic      [31:0]             prdata,                   // apb read data
	output logic                         pready,                   // apb ready
	output logic                         pslverr,                  // apb error
	input  wire logic                    sleep_exec,               // core ran sleep
	input  wire logic                    watchdog_kick,            // core cleared watchdog
	input  wire logic                    port_access,              // file/bit op on port
	input  wire logic                    port_pin0,                // pin 0 level
	input  wire logic                    port_pin1,                // pin 1 level
	input  wire logic                    shared_clear_program_pin, // shared pin level
	input  wire swc_pad_t                core_pad,                 // pad drive from core
	output swc_pad_t                     pad,                      // pad drive to pins
	output logic                         clear_pin_oe,             // shared pin drive
	output logic                         core_reset_n,             // device reset, low
	output logic                         osc_drive_en,             // oscillator driver on
	output logic                         sleeping,                 // in power-down
	output swc_flags_t                   flags,                    // reset-cause flags
	output logic                         irq                       // interrupt, high
);

	// state and registers
	swc_state_t                 state_reg;
	swc_state_t                 state_next;
	swc_flags_t                 flags_reg;
	swc_flags_t                 flags_next;
	swc_wpins_t                 snap_reg;
	swc_wpins_t                 snap_next;
	swc_pad_t                   pad_reg;
	swc_pad_t                   pad_next;
	logic [`SWC_OPT_W-1:0]      option_reg;
	logic [`SWC_OPT_W-1:0]      option_next;
	logic [`SWC_IRQ_W-1:0]      irq_stat_reg;
	logic [`SWC_IRQ_W-1:0]      irq_stat_next;
	logic [`SWC_IRQ_W-1:0]      irq_mask_reg;
	logic [`SWC_IRQ_W-1:0]      irq_mask_next;
	logic                       core_reset_n_reg;
	logic                       osc_en_reg;
	logic [31:0]                prdata_reg;
	logic                       pslverr_reg;

	// watched pins, live
	swc_wpins_t                 live_pins;
	wire logic                  master_clear_n;
	wire logic                  clear_mode;
	wire logic                  pin_wake_enable_n;
	wire logic                  watchdog_en;

	// watchdog
	logic [`SWC_WATCHDOG_W-1:0] watchdog_counter;
	logic                       watchdog_expire;
	wire logic                  watchdog_clear;

	// events
	wire logic                  in_sleep;
	wire logic                  clear_active;
	wire logic                  pin_mismatch;
	wire logic                  pin_change_wake;
	wire logic                  sleep_enter;
	wire logic                  wake_clear;
	wire logic                  wake_watchdog;
	wire logic                  wake_pin;
	wire logic                  wake_any;
	wire logic                  run_watchdog_reset;
	wire logic [`SWC_IRQ_W-1:0] irq_events;

	// apb decode
	wire logic                  apb_setup;
	wire logic                  apb_access;
	wire logic                  apb_wr;
	wire logic                  hit_status;
	wire logic                  hit_option;
	wire logic                  hit_state;
	wire logic                  hit_irq_stat;
	wire logic                  hit_irq_mask;
	wire logic                  addr_hit;
	wire logic [31:0]           rd_mux;
	wire logic [31:0]           status_word;
	wire logic [31:0]           state_word;

	// option fields
	assign pin_wake_enable_n = option_reg[`SWC_OPT_PIN_WAKE_EN_N];
	assign clear_mode        = option_reg[`SWC_OPT_CLEAR_MODE];
	assign watchdog_en       = option_reg[`SWC_OPT_WATCHDOG_EN];

	// watched pins; the shared pin doubles as the external clear
	assign live_pins = {shared_clear_program_pin, // pin 3
		port_pin1,                                // pin 1
		port_pin0};                               // pin 0
	assign master_clear_n = shared_clear_program_pin;
	assign clear_active   = clear_mode && !master_clear_n;

	assign in_sleep = (state_reg == ST_SLEEP);

	// sleep is honoured only from run and never while a reset is being raised
	assign sleep_enter = !in_sleep && sleep_exec && !clear_active &&
		!run_watchdog_reset;

	// compare against the last-read snapshot, not the last pin level, so a
	// mismatch left over from before sleep wakes on the first sleep cycle
	assign pin_mismatch    = (live_pins != snap_reg);
	assign pin_change_wake = pin_mismatch && !pin_wake_enable_n;

	// wake sources, external clear first, then watchdog, then pin change
	assign wake_clear    = in_sleep && clear_active;
	assign wake_watchdog = in_sleep && !clear_active && watchdog_expire;
	assign wake_pin      = in_sleep && !clear_active && !watchdog_expire &&
		pin_change_wake;
	assign wake_any      = wake_clear || wake_watchdog || wake_pin;

	// watchdog expiry while running resets the device internally only
	assign run_watchdog_reset = !in_sleep && watchdog_expire;

	// watchdog restarts on the core's kick, on sleep entry and on any wake
	assign watchdog_clear = watchdog_kick || sleep_enter ||
		wake_any;

	// the counter keeps running through power-down while enabled
	swc_watchdog u_watchdog (
		.pclk    (pclk),
		.presetn (presetn),
		.run_en  (watchdog_en),
		.clear   (watchdog_clear),
		.count   (watchdog_counter),
		.expire  (watchdog_expire)
	);

	// sleep state machine
	always_comb begin
		state_next = state_reg;
		unique case (state_reg)
			ST_RUN: begin
				if (sleep_enter) begin
					state_next = ST_SLEEP;
				end
			end
			ST_SLEEP: begin
				if (wake_any) begin
					state_next = ST_RUN;
				end
			end
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_reg <= ST_RUN;
		end else begin
			state_reg <= state_next;
		end
	end

	// reset-cause flags; the external clear is not among the causes that
	// touch them, so a clear pulse leaves them as they were
	always_comb begin
		flags_next = flags_reg;
		if (sleep_enter) begin
			flags_next.timeout_flag_n   = 1'b1;
			flags_next.powerdown_flag_n = 1'b0;
		end
		if (watchdog_expire && !wake_clear) begin
			flags_next.timeout_flag_n = 1'b0;
			flags_next.pin_wake_flag  = 1'b0;
		end
		if (wake_pin) begin
			flags_next.pin_wake_flag = 1'b1;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			flags_reg <= '{pin_wake_flag: 1'b0, timeout_flag_n: 1'b1,
				powerdown_flag_n: 1'b1};
		end else begin
			flags_reg <= flags_next;
		end
	end

	// snapshot of watched pins on every port file or bit operation
	assign snap_next = port_access ? live_pins : snap_reg;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			snap_reg <= '0;
		end else begin
			snap_reg <= snap_next;
		end
	end

	// pads follow the core one cycle late while running and freeze in sleep;
	// freezing at the entry edge keeps what the core drove before sleeping
	assign pad_next = (in_sleep || sleep_enter) ? pad_reg : core_pad;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pad_reg <= '0;
		end else begin
			pad_reg <= pad_next;
		end
	end

	// oscillator driver off for the whole of power-down
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			osc_en_reg <= 1'b1;
		end else if (sleep_enter) begin
			osc_en_reg <= 1'b0;
		end else if (wake_any) begin
			osc_en_reg <= 1'b1;
		end
	end

	// device reset: level while the external clear is held, one cycle for a
	// wake or a watchdog expiry; no wake path resumes the core in place
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			core_reset_n_reg <= 1'b0;
		end else begin
			core_reset_n_reg <= !(clear_active || wake_any ||
				run_watchdog_reset);
		end
	end

	// the shared pin is an input only; resets never pull it low
	assign clear_pin_oe = 1'b0;

	// interrupt sources: sleep entry, wake-up, watchdog expiry
	assign irq_events[`SWC_IRQ_SLEEP]    = sleep_enter;
	assign irq_events[`SWC_IRQ_WAKE]     = wake_any;
	assign irq_events[`SWC_IRQ_WATCHDOG] = watchdog_expire;

	// apb phase decode; the slave never waits
	assign apb_setup  = psel && !penable;
	assign apb_access = psel && penable;
	assign apb_wr     = apb_access && pwrite;

	assign hit_status   = (paddr == `SWC_OFF_STATUS);
	assign hit_option   = (paddr == `SWC_OFF_OPTION);
	assign hit_state    = (paddr == `SWC_OFF_STATE);
	assign hit_irq_stat = (paddr == `SWC_OFF_IRQ_STAT);
	assign hit_irq_mask = (paddr == `SWC_OFF_IRQ_MASK);
	assign addr_hit     = hit_status || hit_option || hit_state ||
		hit_irq_stat || hit_irq_mask;

	// status word: flags in their layout, other bits zero
	assign status_word = {24'h00_0000, flags_reg.pin_wake_flag, 2'h0,
		flags_reg.timeout_flag_n, flags_reg.powerdown_flag_n, 3'h0};

	// state word: sleep bit, snapshot, live pins
	assign state_word = {25'h000_0000, live_pins, snap_reg, in_sleep};

	assign rd_mux = hit_status   ? status_word :
		hit_option   ? {24'h00_0000, option_reg} :
		hit_state    ? state_word :
		hit_irq_stat ? {29'h0000_0000, irq_stat_reg} :
		hit_irq_mask ? {29'h0000_0000, irq_mask_reg} : 32'h0000_0000;

	// option register: software steers watchdog, clear mode and pin wake
	assign option_next = (apb_wr && hit_option) ? pwdata[`SWC_OPT_W-1:0] :
		option_reg;

	// irq status: write one to clear; a new event in the same cycle wins
	assign irq_stat_next = (irq_stat_reg & ~((apb_wr && hit_irq_stat) ?
		pwdata[`SWC_IRQ_W-1:0] : `SWC_IRQ_W'(0))) | irq_events;

	assign irq_mask_next = (apb_wr && hit_irq_mask) ? pwdata[`SWC_IRQ_W-1:0] :
		irq_mask_reg;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			option_reg   <= `SWC_OPT_RESET;
			irq_stat_reg <= '0;
			irq_mask_reg <= '0;
		end else begin
			option_reg   <= option_next;
			irq_stat_reg <= irq_stat_next;
			irq_mask_reg <= irq_mask_next;
		end
	end

	// read data and error are taken at the setup edge so that they come from
	// flops during the access phase; state may move one cycle meanwhile
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_reg  <= '0;
			pslverr_reg <= 1'b0;
		end else if (apb_setup) begin
			prdata_reg  <= pwrite ? 32'h0000_0000 : rd_mux;
			pslverr_reg <= !addr_hit;
		end
	end

	// outputs
	assign prdata       = prdata_reg;
	assign pslverr      = pslverr_reg && apb_access;
	assign pready       = apb_access;
	assign pad          = pad_reg;
	assign core_reset_n = core_reset_n_reg;
	assign osc_drive_en = osc_en_reg;
	assign sleeping     = in_sleep;
	assign flags        = flags_reg;
	assign irq          = |(irq_stat_reg & irq_mask_reg);

endmodule

/* swc_monitor.sv */
// assertion checker on the sleep/wake control ports
`timescale 1ns/1ns
module swc_monitor
	import swc_pkg::*;
(
	input wire logic       pclk,         // block clock
	input wire logic       presetn,      // async reset, low
	input wire logic       sleep_exec,   // sleep pulse
	input wire swc_pad_t   pad,          // pad drive out
	input wire logic       clear_pin_oe, // shared pin drive
	input wire logic       core_reset_n, // device reset
	input wire logic       osc_drive_en, // oscillator on
	input wire logic       sleeping,     // power-down state
	input wire swc_flags_t flags         // cause flags
);
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	// entry and its side effects
	property p_entry; $rose(sleeping) |-> $past(sleep_exec); endproperty
	a_entry: assert property (p_entry) else $error("sleep entered without instruction");
	property p_entry_fx;
		$rose(sleeping) |-> flags.timeout_flag_n && !flags.powerdown_flag_n && !osc_drive_en;
	endproperty
	a_entry_fx: assert property (p_entry_fx) else $error("sleep entry effects wrong");
	property p_pad_hold; sleeping |-> $stable(pad); endproperty
	a_pad_hold: assert property (p_pad_hold) else $error("pads moved in sleep");
	property p_no_drive; !clear_pin_oe; endproperty
	a_no_drive: assert property (p_no_drive) else $error("shared pin driven");
	// a wake is always a device reset with the oscillator back on
	property p_wake; $fell(sleeping) |-> !core_reset_n && osc_drive_en; endproperty
	a_wake: assert property (p_wake) else $error("wake without reset");
	property p_to_clr; $fell(flags.timeout_flag_n) |-> !core_reset_n; endproperty
	a_to_clr: assert property (p_to_clr) else $error("timeout flag cleared without reset");
	property p_pd_clr; $fell(flags.powerdown_flag_n) |-> $rose(sleeping); endproperty
	a_pd_clr: assert property (p_pd_clr) else $error("powerdown flag cleared outside sleep");
	property p_pw_set; $rose(flags.pin_wake_flag) |-> $fell(sleeping); endproperty
	a_pw_set: assert property (p_pw_set) else $error("pin wake flag set outside wake");
	// flags only move on a reset or on sleep entry
	property p_hold;
		core_reset_n && $past(core_reset_n) && !$rose(sleeping) |-> $stable(flags);
	endproperty
	a_hold: assert property (p_hold) else $error("cause flags changed");
	c_sleep: cover property ($rose(sleeping));
	c_wdt: cover property ($fell(flags.timeout_flag_n));
	c_pin: cover property ($rose(flags.pin_wake_flag));
endmodule

/* swc_core_model.sv */
// core-side model: sleep instruction, port reads and watched pin levels
`timescale 1ns/1ns
module swc_core_model
	import swc_pkg::*;
(
	input  wire logic  pclk,          // block clock
	output logic       sleep_exec,    // sleep pulse
	output logic       watchdog_kick, // watchdog clear pulse
	output logic       port_access,   // port read pulse
	output swc_wpins_t pins           // watched pin levels
);
	// pins idle high so the shared clear stays released
	initial begin
		sleep_exec    = 1'b0;
		watchdog_kick = 1'b0;
		port_access   = 1'b0;
		pins          = 3'b111;
	end
	// software reads the port right before sleeping, or skips it on purpose
	task automatic sleep_now(input logic fresh, input logic kick = 1'b0);
		@(posedge pclk);
		port_access   <= fresh;
		watchdog_kick <= kick;
		@(posedge pclk);
		port_access   <= 1'b0;
		watchdog_kick <= 1'b0;
		sleep_exec    <= 1'b1;
		@(posedge pclk);
		sleep_exec    <= 1'b0;
	endtask
	// outside party moves pins, the shared one acting as external clear
	task automatic set_pins(input swc_wpins_t v);
		@(posedge pclk);
		pins <= v;
	endtask
endmodule

/* test_sleep_wakeup_control.sv */
// self-checking bench for the sleep/wake control block
`timescale 1ns/1ns
module test_sleep_wakeup_control;
	import swc_pkg::*;
	typedef struct {logic [7:0] a; logic [32:0] e;} swc_note_t;
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, irq;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata;
	logic        sleep_exec, watchdog_kick, port_access;
	logic        clear_pin_oe, core_reset_n, osc_drive_en, sleeping;
	swc_wpins_t  pins;
	swc_pad_t    core_pad, pad;
	swc_flags_t  flags;
	swc_note_t   note_q[$];
	int          n_fail, compares, n, n_w;
	logic [15:0] rnd;

	swc_sleep_wakeup_control dut_u (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .sleep_exec(sleep_exec),
		.watchdog_kick(watchdog_kick), .port_access(port_access),
		.port_pin0(pins.pin0), .port_pin1(pins.pin1), .shared_clear_program_pin(pins.pin3),
		.core_pad(core_pad), .pad(pad), .clear_pin_oe(clear_pin_oe),
		.core_reset_n(core_reset_n), .osc_drive_en(osc_drive_en),
		.sleeping(sleeping), .flags(flags), .irq(irq));
	swc_core_model core_u (.pclk(pclk), .sleep_exec(sleep_exec),
		.watchdog_kick(watchdog_kick), .port_access(port_access), .pins(pins));

	function automatic logic [15:0] lfsr(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction
	// status word: pin wake bit 7, timeout bit 4, powerdown bit 3
	function automatic logic [31:0] st(input logic pw, input logic to, input logic pd);
		return {24'h0, pw, 2'b00, to, pd, 3'b000};
	endfunction
	task automatic chk(input string nm, input logic [32:0] e, input logic [32:0] g);
		compares++;
		if (g !== e) begin
			n_fail++;
			$display("[ERR] %s exp %h got %h", nm, e, g);
		end
	endtask
	task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
		@(posedge pclk);
		psel   <= 1'b1;
		pwrite <= w;
		paddr  <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(a, 1'b1, d);
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic err = 1'b0);
		note_q.push_back('{a, {err, e}});
		apb(a, 1'b0, {16'h0000, rnd});
	endtask
	// counts falling edges until sleeping, or the device reset, reaches v
	task automatic wait_on(input logic rst, input logic v, input int lim);
		n = 0;
		do begin
			@(negedge pclk);
			n++;
		end while (((rst ? core_reset_n : sleeping) !== v) && n < lim);
	endtask
	task automatic close_out();
		$display("compares %0d n_fail %0d", compares, n_fail);
		if (n_fail == 0 && compares > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	initial begin
		pclk = 1'b0;
		forever #5 pclk = ~pclk;
	end
	// pads churn every cycle so a missing freeze shows up
	always @(posedge pclk) begin
		rnd      <= lfsr(rnd);
		core_pad <= rnd[9:0];
	end
	// read results are compared at the edge that samples pready
	always @(posedge pclk) begin
		swc_note_t nt;
		if (psel && penable && pready === 1'b1 && !pwrite && note_q.size() > 0) begin
			nt = note_q.pop_front();
			chk($sformatf("reg %h", nt.a), nt.e, {pslverr, prdata});
		end
	end
	// a hang counts as a failure
	initial begin
		#400000;
		n_fail++;
		close_out();
	end

	initial begin
		{psel, penable, pwrite, paddr, pwdata} = '0;
		rnd      = 16'd64601;
		core_pad = '0;
		n_fail   = 0;
		compares = 0;
		presetn  = 1'b0;
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		// power-up values, a read-only write and an unmapped read
		rd(8'h00, st(0, 1, 1));
		rd(8'h04, 32'h82);
		wr(8'h00, {16'h0000, rnd});
		rd(8'h00, st(0, 1, 1));
		rd(8'h14 + {2'b00, rnd[3:0], 2'b00}, 32'h0, 1'b1);
		// stale mismatch with no port read: wakes on the first sleep edge
		wr(8'h04, 32'h02);
		core_u.set_pins(rnd[2:0] | 3'b100);
		core_u.sleep_now(1'b0, rnd[4]);
		wait_on(0, 0, 10);
		chk("stale wake cycles", 33'd2, 33'(n));
		rd(8'h00, st(1, 1, 0));
		// interrupt masked, raised, then cleared by writing ones
		@(negedge pclk);
		chk("irq masked", 33'd0, 33'(irq));
		wr(8'h10, 32'h2);
		@(negedge pclk);
		chk("irq raised", 33'd1, 33'(irq));
		wr(8'h0c, 32'h7);
		@(negedge pclk);
		chk("irq cleared", 33'd0, 33'(irq));
		// watchdog wakes from sleep, then times out while running
		wr(8'h04, 32'h81);
		core_u.sleep_now(1'b1, rnd[6]);
		wait_on(0, 0, 5000);
		chk("sleep watchdog cycles", 33'd4097, 33'(n));
		wait_on(1, 1, 10);
		n_w = n;
		wait_on(1, 0, 5000);
		chk("run watchdog cycles", 33'd4096, 33'(n_w + n));
		wr(8'h04, 32'h82);
		rd(8'h00, st(0, 0, 0));
		// clear pulse while running leaves the flags alone
		core_u.set_pins(3'b011);
		wait_on(1, 0, 5);
		chk("clear reset", 33'd0, 33'(core_reset_n));
		core_u.set_pins(3'b111);
		rd(8'h00, st(0, 0, 0));
		// each watched pin wakes after a fresh port read
		wr(8'h04, 32'h00);
		for (int i = 0; i < 3; i++) begin
			core_u.sleep_now(1'b1);
			wait_on(0, 0, 10);
			chk("asleep after read", 33'd10, 33'(n));
			core_u.set_pins(core_u.pins ^ (3'b001 << i));
			wait_on(0, 0, 5);
			chk("pin wake", 33'd0, 33'(sleeping));
			rd(8'h00, st(1, 1, 0));
		end
		// wake-on-change disabled; the clear input still wakes
		wr(8'h04, 32'h80);
		core_u.set_pins(3'b110);
		core_u.sleep_now(1'b1);
		core_u.set_pins(3'b111);
		wait_on(0, 0, 10);
		chk("no wake when disabled", 33'd10, 33'(n));
		wr(8'h04, 32'h82);
		core_u.set_pins(3'b011);
		wait_on(0, 0, 5);
		chk("clear wake", 33'd0, 33'(sleeping));
		repeat (3) @(negedge pclk);
		chk("reset held", 33'd0, 33'(core_reset_n));
		core_u.set_pins(3'b111);
		rd(8'h00, st(1, 1, 0));
		close_out();
	end
endmodule

bind swc_sleep_wakeup_control swc_monitor mon_u (
	.pclk(pclk), .presetn(presetn), .sleep_exec(sleep_exec), .pad(pad),
	.clear_pin_oe(clear_pin_oe), .core_reset_n(core_reset_n),
	.osc_drive_en(osc_drive_en), .sleeping(sleeping), .flags(flags));
